//--- lfazc_control.v
// Register access over APB was decided locally.
`include "lfazc_map.vh"

module lfazc_control #(
	parameter ADDR_W      = 8,
	parameter HALF_CYCLES = `LFAZC_HALF_RX_CYCLES
) (
	// Clock and reset
	input  wire              sys_clk,
	input  wire              reset_n,
	// APB slave
	input  wire              psel,
	input  wire              penable,
	input  wire              pwrite,
	input  wire [ADDR_W-1:0] paddr,
	input  wire [31:0]       pwdata,
	output reg  [31:0]       prdata,
	output wire              pready,
	output wire              pslverr,
	// Receiver control, same clock
	input  wire              lf_soft_reset,
	input  wire              data_receive_mode,
	input  wire [2:0]        zeroing_edge_count,
	input  wire              rx_error,
	input  wire              on_time_remaining,
	// Asynchronous inputs from the front end
	input  wire              zeroing_enable_input,
	input  wire              demod_data_input,
	input  wire              dequalify_active_input,
	// Trim and sequencer outputs
	output wire              trim_edit_enable,
	output wire [7:0]        sensitivity_trim_first,
	output wire [7:0]        sensitivity_trim_second,
	output reg  [7:0]        trim_effective_q,
	output reg               seq_nominal_q,
	output reg               seq_release_rect_q,
	output reg               seq_release_amp_q,
	output reg               seq_all_short_q,
	// Auto-zero and error handling outputs
	output wire              auto_zero_control,
	output wire              zeroing_start,
	output wire              on_error_behaviour,
	output reg               end_on_time_q,
	output reg               return_to_sniff_q,
	output wire              carrier_check_short
);

	// Register state
	reg  [7:0] seq_ctrl_q;
	reg  [7:0] trig_ctrl_q;
	reg  [7:0] trim_first_q;
	reg  [7:0] trim_second_q;
	reg        dqs_q;
	reg        err_q;

	// Synchronisers, two flops each
	reg  [2:0] sync1_q;
	reg  [2:0] sync2_q;

	wire       az_enable_s;
	wire       data_s;
	wire       dqs_s;
	wire       setup;
	wire       wr_access;
	wire [7:0] wbyte;
	wire [7:0] trig_read;
	wire [7:0] seq_read;

	// Address decode; used for read, error and write
	function [2:0] decode;
		input [ADDR_W-1:0] addr;
		begin
			if (addr[1:0] != 2'h0)
				decode = 3'h0;
			else if (addr[ADDR_W-1:2] == `LFAZC_IDX_SEQ_CTRL)
				decode = 3'h1;
			else if (addr[ADDR_W-1:2] == `LFAZC_IDX_TRIG_CTRL)
				decode = 3'h2;
			else if (addr[ADDR_W-1:2] == `LFAZC_IDX_TRIM_FIRST)
				decode = 3'h3;
			else if (addr[ADDR_W-1:2] == `LFAZC_IDX_TRIM_SECOND)
				decode = 3'h4;
			else
				decode = 3'h0;
		end
	endfunction

	// Front-end levels cross in through two flops before any use
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
		end else begin
			sync1_q <= {dequalify_active_input, demod_data_input, zeroing_enable_input};
			sync2_q <= sync1_q;
		end
	end

	assign az_enable_s = sync2_q[0];
	assign data_s      = sync2_q[1];
	assign dqs_s       = sync2_q[2];

	// APB: zero wait states, so every access ends in its first access cycle
	assign pready    = 1'b1;
	assign setup     = psel & ~penable;
	assign wr_access = psel & penable & pwrite & pready & ~err_q;
	assign pslverr   = psel & penable & err_q;
	assign wbyte     = pwdata[7:0];

	// Read images; reserved bits read as zero
	assign seq_read  = {4'h0, seq_ctrl_q[3:0]};
	assign trig_read = {trig_ctrl_q[7:6], dqs_q, trig_ctrl_q[4:0]};

	// Read data and error captured in setup so they are stable in access
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata <= 32'h0;
			err_q  <= 1'b0;
		end else if (setup) begin
			err_q <= (decode(paddr) == 3'h0);
			case (decode(paddr))
				3'h1:    prdata <= {24'h0, seq_read};
				3'h2:    prdata <= {24'h0, trig_read};
				3'h3:    prdata <= {24'h0, trim_first_q};
				3'h4:    prdata <= {24'h0, trim_second_q};
				default: prdata <= 32'h0;
			endcase
		end
	end

	// Sequencer control; soft reset wins over a write in the same cycle
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			seq_ctrl_q <= `LFAZC_SEQ_CTRL_RST;
		end else if (lf_soft_reset) begin
			seq_ctrl_q <= `LFAZC_SEQ_CTRL_RST;
		end else if (wr_access && decode(paddr) == 3'h1) begin
			seq_ctrl_q <= {4'h0, wbyte[3:0]};
		end
	end

	// Trigger control; status bit is held apart and never written
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			trig_ctrl_q <= `LFAZC_TRIG_CTRL_RST;
		end else if (lf_soft_reset) begin
			trig_ctrl_q <= `LFAZC_TRIG_CTRL_RST;
		end else if (wr_access && decode(paddr) == 3'h2) begin
			trig_ctrl_q <= {wbyte[7:6], 1'b0, wbyte[4:0]};
		end
	end

	// De-Q status follows the front end; soft reset does not clear it
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			dqs_q <= 1'b0;
		else
			dqs_q <= dqs_s;
	end

	// Trim registers; locked writes are dropped without an error
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			trim_first_q  <= `LFAZC_TRIM_RST;
			trim_second_q <= `LFAZC_TRIM_RST;
		end else if (wr_access && seq_ctrl_q[`LFAZC_SEQ_TEE_BIT]) begin
			if (decode(paddr) == 3'h3)
				trim_first_q <= wbyte;
			if (decode(paddr) == 3'h4)
				trim_second_q <= wbyte;
		end
	end

	assign trim_edit_enable        = seq_ctrl_q[`LFAZC_SEQ_TEE_BIT];
	assign sensitivity_trim_first  = trim_first_q;
	assign sensitivity_trim_second = trim_second_q;

	// Sequence select, registered so outputs come from flops
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			seq_nominal_q      <= 1'b0;
			seq_release_rect_q <= 1'b0;
			seq_release_amp_q  <= 1'b0;
			seq_all_short_q    <= 1'b0;
		end else begin
			seq_nominal_q      <= 1'b0;
			seq_release_rect_q <= 1'b0;
			seq_release_amp_q  <= 1'b0;
			seq_all_short_q    <= 1'b0;
			case (seq_ctrl_q[`LFAZC_SEQ_SEL_HI:`LFAZC_SEQ_SEL_LO])
				`LFAZC_SEQ_NOMINAL:   seq_nominal_q      <= 1'b1;
				`LFAZC_SEQ_AMP_RECT:  seq_release_rect_q <= 1'b1;
				`LFAZC_SEQ_AMP_INPUT: seq_release_amp_q  <= 1'b1;
				default:              seq_all_short_q    <= 1'b1;
			endcase
		end
	end

	// Effective trim; shift saturates at zero rather than wrapping
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			trim_effective_q <= `LFAZC_TRIM_RST;
		else if (!seq_ctrl_q[`LFAZC_SEQ_SHIFT_BIT])
			trim_effective_q <= trim_first_q;
		else if (trim_first_q < `LFAZC_TRIM_SHIFT)
			trim_effective_q <= 8'h00;
		else
			trim_effective_q <= trim_first_q - `LFAZC_TRIM_SHIFT;
	end

	// Error handling per on-behaviour bit, follows rx_error one cycle later
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			end_on_time_q     <= 1'b0;
			return_to_sniff_q <= 1'b0;
		end else begin
			return_to_sniff_q <= rx_error & on_error_behaviour & on_time_remaining;
			end_on_time_q     <= rx_error & ~(on_error_behaviour & on_time_remaining);
		end
	end

	assign on_error_behaviour  = trig_ctrl_q[`LFAZC_TRG_ONB_BIT];
	// Codes 01 and 10 use the short packet method
	assign carrier_check_short = trig_ctrl_q[`LFAZC_TRG_CHK_HI] ^ trig_ctrl_q[`LFAZC_TRG_CHK_LO];

	// Auto-zero release delay
	lfazc_release_delay #(
		.HALF_CYCLES  (HALF_CYCLES),
		.CNT_W        (12)
	) u_release (
		.sys_clk      (sys_clk),
		.reset_n      (reset_n),
		.az_enable    (az_enable_s),
		.delay_select (trig_ctrl_q[`LFAZC_TRG_DLY_HI:`LFAZC_TRG_DLY_LO]),
		.az_control_q (auto_zero_control)
	);

	// Auto-zero triggering in data receive mode
	lfazc_trigger u_trigger (
		.sys_clk         (sys_clk),
		.reset_n         (reset_n),
		.receive_mode    (data_receive_mode),
		.trigger_select  (trig_ctrl_q[`LFAZC_TRG_SEL_HI:`LFAZC_TRG_SEL_LO]),
		.edge_count      (zeroing_edge_count),
		.data_level      (data_s),
		.zeroing_start_q (zeroing_start)
	);

endmodule // lfazc_control

//--- lfazc_map.vh
// Notes on behaviour
// - Trim registers writable only while edit enabled
// - Sequencer low bits select auto-zero sequence
// - Sequencer bit 2 shifts sensitivity minus four
// - Sequencer register loads 0x01 on resets
// - Release delay: none, half, one-and-half periods
// - De-Q status read-only, follows front end, not cleared by soft reset
// - Trigger after edge count, optionally randomised
// - Data-level codes also need data low/high
// - Trigger register loads 0x01 on resets, except De-Q status on soft reset
// - On-behaviour bit: end on time or sniff
// - Carrier check: long or short packet method
`ifndef LFAZC_MAP_VH
`define LFAZC_MAP_VH

// Register indices; byte address is four times the index
`define LFAZC_IDX_SEQ_CTRL     6'h28
`define LFAZC_IDX_TRIG_CTRL    6'h29
`define LFAZC_IDX_TRIM_FIRST   6'h30
`define LFAZC_IDX_TRIM_SECOND  6'h31

// Reset values
`define LFAZC_SEQ_CTRL_RST     8'h01
`define LFAZC_TRIG_CTRL_RST    8'h01
`define LFAZC_TRIM_RST         8'h00

// Sequencer control fields
`define LFAZC_SEQ_TEE_BIT      3
`define LFAZC_SEQ_SHIFT_BIT    2
`define LFAZC_SEQ_SEL_HI       1
`define LFAZC_SEQ_SEL_LO       0

// Trigger control fields
`define LFAZC_TRG_DLY_HI       7
`define LFAZC_TRG_DLY_LO       6
`define LFAZC_TRG_DQS_BIT      5
`define LFAZC_TRG_SEL_HI       4
`define LFAZC_TRG_SEL_LO       3
`define LFAZC_TRG_ONB_BIT      2
`define LFAZC_TRG_CHK_HI       1
`define LFAZC_TRG_CHK_LO       0

// Sequence codes
`define LFAZC_SEQ_NOMINAL      2'h0
`define LFAZC_SEQ_AMP_RECT     2'h1
`define LFAZC_SEQ_AMP_INPUT    2'h2
`define LFAZC_SEQ_ALL_SHORT    2'h3

// Release delay codes
`define LFAZC_DLY_HALF         2'h2
`define LFAZC_DLY_ONE_HALF     2'h3

// Half periods in the long release delay
`define LFAZC_DLY_LONG_MULT    3

// Trigger codes
`define LFAZC_TRG_COUNT        2'h0
`define LFAZC_TRG_RANDOM       2'h1
`define LFAZC_TRG_DATA_LOW     2'h2
`define LFAZC_TRG_DATA_HIGH    2'h3

// Sensitivity shift in trim steps
`define LFAZC_TRIM_SHIFT       8'h04

// Timing: system clock and receiver clock in kHz
`define LFAZC_SYS_CLK_KHZ      250000
`define LFAZC_RX_CLK_KHZ       125
`define LFAZC_HALF_RX_CYCLES   (`LFAZC_SYS_CLK_KHZ / (2 * `LFAZC_RX_CLK_KHZ))

// Random generator seed, any nonzero value
`define LFAZC_LFSR_SEED        8'hA5

`endif

//--- lfazc_release_delay.v
`include "lfazc_map.vh"

module lfazc_release_delay #(
	parameter HALF_CYCLES = `LFAZC_HALF_RX_CYCLES,
	parameter CNT_W       = 12
) (
	// Clock and reset
	input  wire             sys_clk,
	input  wire             reset_n,
	// Control
	input  wire             az_enable,
	input  wire [1:0]       delay_select,
	// Result
	output reg              az_control_q
);

	reg  [CNT_W-1:0] cnt_q;
	reg              en_prev_q;
	reg  [CNT_W-1:0] load;

	// Long delay worked out at full width, then cut to the counter on purpose
	localparam integer LONG_LOAD = `LFAZC_DLY_LONG_MULT * HALF_CYCLES;

	// Delay length for the selected code
	always @* begin
		case (delay_select)
			`LFAZC_DLY_HALF:     load = HALF_CYCLES[CNT_W-1:0];
			`LFAZC_DLY_ONE_HALF: load = LONG_LOAD[CNT_W-1:0];
			default:             load = {CNT_W{1'b0}};
		endcase
	end

	// Rising edge passes at once; falling edge waits out the delay
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q        <= {CNT_W{1'b0}};
			en_prev_q    <= 1'b0;
			az_control_q <= 1'b0;
		end else begin
			en_prev_q <= az_enable;
			if (az_enable) begin
				az_control_q <= 1'b1;
				cnt_q        <= {CNT_W{1'b0}};
			end else if (en_prev_q) begin
				cnt_q        <= load;
				az_control_q <= (load != {CNT_W{1'b0}});
			end else if (cnt_q != {CNT_W{1'b0}}) begin
				cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
				if (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1})
					az_control_q <= 1'b0;
			end
		end
	end

endmodule // lfazc_release_delay

//--- lfazc_trigger.v
`include "lfazc_map.vh"

module lfazc_trigger (
	// Clock and reset
	input  wire       sys_clk,
	input  wire       reset_n,
	// Control
	input  wire       receive_mode,
	input  wire [1:0] trigger_select,
	input  wire [2:0] edge_count,
	input  wire       data_level,
	// Result
	output reg        zeroing_start_q
);

	reg  [3:0] cnt_q;
	reg  [3:0] target_q;
	reg  [7:0] lfsr_q;
	reg        data_prev_q;
	wire       data_edge;
	wire       reached;
	reg        level_ok;

	// Target count, with a random -1, 0 or +1 in random mode
	function [3:0] next_target;
		input [1:0] sel;
		input [2:0] base;
		input [1:0] rnd;
		begin
			next_target = {1'b0, base};
			if (sel == `LFAZC_TRG_RANDOM) begin
				if (rnd == 2'h0 && base != 3'h0)
					next_target = {1'b0, base} - 4'h1;
				else if (rnd == 2'h2)
					next_target = {1'b0, base} + 4'h1;
			end
		end
	endfunction

	assign data_edge = data_level ^ data_prev_q;
	assign reached   = (cnt_q >= target_q);

	// Data level qualifier
	always @* begin
		case (trigger_select)
			`LFAZC_TRG_DATA_LOW:  level_ok = ~data_level;
			`LFAZC_TRG_DATA_HIGH: level_ok = data_level;
			default:              level_ok = 1'b1;
		endcase
	end

	// Edge counter; restarts after each start and outside receive mode
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q           <= 4'h0;
			target_q        <= 4'h0;
			lfsr_q          <= `LFAZC_LFSR_SEED;
			data_prev_q     <= 1'b0;
			zeroing_start_q <= 1'b0;
		end else begin
			lfsr_q      <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
			data_prev_q <= data_level;
			if (!receive_mode) begin
				cnt_q           <= 4'h0;
				target_q        <= next_target(trigger_select, edge_count, lfsr_q[1:0]);
				zeroing_start_q <= 1'b0;
			end else if (reached && level_ok) begin
				cnt_q           <= 4'h0;
				target_q        <= next_target(trigger_select, edge_count, lfsr_q[1:0]);
				zeroing_start_q <= 1'b1;
			end else begin
				zeroing_start_q <= 1'b0;
				if (data_edge && !reached)
					cnt_q <= cnt_q + 4'h1;
			end
		end
	end

endmodule // lfazc_trigger

//--- lfazc_control_chk.sv
module lfazc_control_chk (
	// Clock and reset
	input logic        sys_clk,
	input logic        reset_n,
	// Register bus
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [7:0]  paddr,
	input logic [31:0] pwdata,
	// Receiver inputs
	input logic        lf_soft_reset,
	input logic        data_receive_mode,
	input logic        rx_error,
	input logic        on_time_remaining,
	input logic        zeroing_enable_input,
	// Watched outputs
	input logic        trim_edit_enable,
	input logic [7:0]  sensitivity_trim_first,
	input logic        seq_nominal_q,
	input logic        seq_release_rect_q,
	input logic        seq_release_amp_q,
	input logic        seq_all_short_q,
	input logic        auto_zero_control,
	input logic        zeroing_start,
	input logic        on_error_behaviour,
	input logic        end_on_time_q,
	input logic        return_to_sniff_q,
	input logic        carrier_check_short
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// Write data of the previous cycle, so $past needs no part select
	logic [31:0] wd_q;
	always_ff @(posedge sys_clk) wd_q <= pwdata;
	// Completed write; the slave never stalls
	wire wr = psel && penable && pwrite && !lf_soft_reset;
	property p_trim_locked;
		wr && paddr == 8'hC0 && !trim_edit_enable |=> $stable(sensitivity_trim_first);
	endproperty
	a_trim_locked: assert property (p_trim_locked) else $error("trim moved while locked");
	property p_seq_hot;
		$past(reset_n) |-> $onehot({seq_nominal_q, seq_release_rect_q,
			seq_release_amp_q, seq_all_short_q});
	endproperty
	a_seq_hot: assert property (p_seq_hot) else $error("sequence decode not one-hot");
	property p_soft;
		lf_soft_reset |=> !trim_edit_enable && carrier_check_short && !on_error_behaviour;
	endproperty
	a_soft: assert property (p_soft) else $error("soft reset values wrong");
	property p_seq_wr;
		wr && paddr == 8'hA0 |=> trim_edit_enable == wd_q[3];
	endproperty
	a_seq_wr: assert property (p_seq_wr) else $error("edit enable not written");
	property p_trig_wr;
		wr && paddr == 8'hA4 |=> on_error_behaviour == wd_q[2] && carrier_check_short == ^wd_q[1:0];
	endproperty
	a_trig_wr: assert property (p_trig_wr) else $error("trigger fields not written");
	property p_sniff;
		rx_error && on_error_behaviour && on_time_remaining |=> return_to_sniff_q && !end_on_time_q;
	endproperty
	a_sniff: assert property (p_sniff) else $error("no return to sniff");
	property p_end;
		rx_error && !(on_error_behaviour && on_time_remaining) |=> end_on_time_q && !return_to_sniff_q;
	endproperty
	a_end: assert property (p_end) else $error("on time not ended");
	property p_idle;
		!data_receive_mode [*2] |=> !zeroing_start;
	endproperty
	a_idle: assert property (p_idle) else $error("start outside receive mode");
	property p_az_rise;
		$rose(zeroing_enable_input) ##1 zeroing_enable_input [*2] |=> auto_zero_control;
	endproperty
	a_az_rise: assert property (p_az_rise) else $error("zeroing control late");
	// Main scenarios reached
	cover property (wr && paddr == 8'hC0 && trim_edit_enable);
	cover property (return_to_sniff_q);
	cover property (zeroing_start);
	cover property ($fell(auto_zero_control));
endmodule // lfazc_control_chk

bind lfazc_control lfazc_control_chk chk_u (.*);

//--- lfazc_control_tb_top.sv
module lfazc_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// Short release delay keeps the run brief
	localparam int HALF = 10;
	logic        sys_clk;
	logic        reset_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        lf_soft_reset;
	logic        data_receive_mode;
	logic [2:0]  zeroing_edge_count;
	logic        rx_error;
	logic        on_time_remaining;
	logic        zeroing_enable_input;
	logic        demod_data_input;
	logic        dequalify_active_input;
	logic        trim_edit_enable;
	logic [7:0]  sensitivity_trim_first;
	logic [7:0]  sensitivity_trim_second;
	logic [7:0]  trim_effective_q;
	logic [3:0]  seq_hot;
	logic        auto_zero_control;
	logic        zeroing_start;
	logic        on_error_behaviour;
	logic        end_on_time_q;
	logic        return_to_sniff_q;
	logic        carrier_check_short;
	logic [31:0] rq;
	logic        re;
	int          bad_count;
	int          total_checks;
	int          starts;

	lfazc_control #(.ADDR_W(8), .HALF_CYCLES(HALF)) dut_u (.*,
		.seq_nominal_q(seq_hot[0]), .seq_release_rect_q(seq_hot[1]),
		.seq_release_amp_q(seq_hot[2]), .seq_all_short_q(seq_hot[3]));

	always #2 sys_clk = ~sys_clk;
	// Start pulses last one cycle, so count them at every edge
	always @(posedge sys_clk) if (zeroing_start === 1'b1) starts++;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One bus transfer; an idle edge first avoids driving psel twice in a step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		// A slave that never answers is left to the watchdog
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rq = prdata;
		re = pslverr;
		{psel, penable} <= 2'h0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rq, exp);
	endtask

	task automatic t_trim;
		apb(1'b1, 8'hC0, 32'h55);
		rdchk(8'hC0, 32'h00);
		apb(1'b1, 8'hA0, 32'h08);
		apb(1'b1, 8'hC0, 32'h55);
		apb(1'b1, 8'hC4, 32'hAA);
		rdchk(8'hC0, 32'h55);
		rdchk(8'hC4, 32'hAA);
		chk(sensitivity_trim_second, 32'hAA);
		chk(trim_effective_q, 32'h55);
		apb(1'b1, 8'hA0, 32'h0C);
		repeat (2) @(posedge sys_clk);
		chk(trim_effective_q, 32'h51);
		$display("trim test done");
	endtask

	task automatic t_seq;
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, 8'hA0, c);
			repeat (2) @(posedge sys_clk);
			chk(seq_hot, 32'h1 << c);
		end
		$display("sequence test done");
	endtask

	// Reserved bits, status bit, soft reset and an unmapped address
	task automatic t_rsvd;
		apb(1'b1, 8'hA0, 32'hF1);
		rdchk(8'hA0, 32'h01);
		apb(1'b1, 8'hA4, 32'hFF);
		rdchk(8'hA4, 32'hDF);
		chk({on_error_behaviour, carrier_check_short}, 32'h2);
		dequalify_active_input <= 1'b1;
		repeat (5) @(posedge sys_clk);
		rdchk(8'hA4, 32'hFF);
		lf_soft_reset <= 1'b1;
		@(posedge sys_clk);
		lf_soft_reset <= 1'b0;
		rdchk(8'hA0, 32'h01);
		rdchk(8'hA4, 32'h21);
		apb(1'b0, 8'h10, 32'h0);
		chk(re, 32'h1);
		$display("reserved test done");
	endtask

	task automatic t_err;
		for (int b = 0; b < 2; b++) begin
			apb(1'b1, 8'hA4, b << 2);
			{rx_error, on_time_remaining} <= 2'h3;
			@(posedge sys_clk);
			rx_error <= 1'b0;
			#1;
			chk({return_to_sniff_q, end_on_time_q}, b ? 32'h2 : 32'h1);
		end
		$display("error test done");
	endtask

	task automatic t_delay;
		int n;
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, 8'hA4, c << 6);
			zeroing_enable_input <= 1'b1;
			repeat (8) @(posedge sys_clk);
			zeroing_enable_input <= 1'b0;
			n = 0;
			do begin
				@(posedge sys_clk);
				#1;
				n++;
			end while (auto_zero_control === 1'b1 && n < 200);
			chk(n, 3 + HALF * (c == 3 ? 3 : c == 2 ? 1 : 0));
		end
		$display("delay test done");
	endtask

	// Two edges, which start the count code and end at the wrong level for the data-level codes, then a third edge to the wanted level
	task automatic t_trig(input logic [1:0] c, input logic s);
		@(posedge sys_clk);
		data_receive_mode <= 1'b0;
		demod_data_input <= s;
		apb(1'b1, 8'hA4, {27'h0, c, 3'h0});
		data_receive_mode <= 1'b1;
		starts = 0;
		repeat (2) begin
			repeat (10) @(posedge sys_clk);
			demod_data_input <= ~demod_data_input;
		end
		repeat (20) @(posedge sys_clk);
		chk(starts, c == 2'h0);
		demod_data_input <= ~demod_data_input;
		repeat (20) @(posedge sys_clk);
		chk(starts, 32'h1);
		$display("trigger test done");
	endtask

	// Random mode: with a count of two the start must follow edge one to three
	task automatic t_rand;
		int k;
		data_receive_mode <= 1'b0;
		apb(1'b1, 8'hA4, 32'h08);
		repeat (2) @(posedge sys_clk);
		data_receive_mode <= 1'b1;
		starts = 0;
		k = 0;
		while (starts == 0 && k < 4) begin
			demod_data_input <= ~demod_data_input;
			k++;
			repeat (10) @(posedge sys_clk);
		end
		chk(k >= 1 && k <= 3, 32'h1);
		chk(starts, 32'h1);
		$display("random trigger test done");
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		sys_clk = 1'b0;
		{reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
		{lf_soft_reset, data_receive_mode, rx_error, on_time_remaining} = '0;
		{zeroing_enable_input, demod_data_input, dequalify_active_input} = '0;
		zeroing_edge_count = 3'h2;
		bad_count = 0;
		total_checks = 0;
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		rdchk(8'hA0, 32'h01);
		rdchk(8'hA4, 32'h01);
		t_trim();
		t_seq();
		t_rsvd();
		t_err();
		t_delay();
		t_trig(2'h0, 1'b0);
		t_trig(2'h2, 1'b1);
		t_trig(2'h3, 1'b0);
		t_rand();
		stop_test();
	end

	// Watchdog: the tests need well under two thousand cycles
	initial begin
		#40000;
		bad_count++;
		stop_test();
	end
endmodule // lfazc_control_tb_top
